// >>> hdl/ibus_watchpoint_control.sv
// Functional notes
// - Three-bit compare type; top bit zero inactive
// - Watch 0: A match, or A and B
// - Watch 1: B match, or A or B
// - Watch 2: C match, or C and D
// - Watch 3: D match, or C or D
// - Per-watch software trap enable, reset zero
// - Dev-port trap enables read-only to software
// - Skip-first-hit ignores first breakpoint match
// - Serialize bit zero forces fetch serialization
// - Show-cycle select: all, flow, indirect, none
// - Serialized when serialize bit zero or show-all
// - New show select acts two instructions later
// - Reset clears the fetch watch control
// - Load/store address direction qualifier, two bits
// - Load/store data compare size field
// - Load/store data signed or unsigned mode
// - Load/store data byte mask, set excludes
`timescale 1ns/1ps
`default_nettype none
module ibus_watchpoint_control (
  input  wire logic                             core_clk,
  input  wire logic                             reset_n,
  input  wire logic                             spr_wr_en,
  input  wire logic                             spr_rd_en,
  input  wire logic [9:0]                       spr_num,
  input  wire logic [31:0]                      spr_wdata,
  output logic [31:0]                           spr_rdata,
  output logic                                  spr_rd_hit,
  input  wire logic                             devport_en_wr,
  input  wire logic [0:3]                       devport_en_data,
  input  wire ibus_watch_pkg::fetch_req_t       fetch_req,
  input  wire logic [3:0][29:0]                 cmp_value,
  input  wire logic                             instr_done,
  output logic [0:3]                            watch_hit,
  output logic [0:3]                            sw_trap,
  output logic [0:3]                            devport_trap,
  output logic                                  fetch_serialize,
  output logic [1:0]                            show_cycle_mode,
  output var ibus_watch_pkg::load_store_ctrl_t  load_store_cfg
);
  import ibus_watch_pkg::*;

  fetch_watch_ctrl_t ctrl_reg,        ctrl_next;
  load_store_ctrl_t  lsu_reg,         lsu_next;
  logic [1:0]        show_active_reg, show_active_next;
  logic              show_pend_reg,   show_pend_next;
  logic              hit_seen_reg,    hit_seen_next;
  logic [0:3]        hit_reg,         hit_next;
  logic [0:3]        sw_trap_reg,     sw_trap_next;
  logic [0:3]        dev_trap_reg,    dev_trap_next;
  logic              serialize_reg,   serialize_next;
  logic [31:0]       rdata_reg,       rdata_next;
  logic              rd_hit_reg,      rd_hit_next;

  logic [3:0][2:0]   cmp_type;
  logic [3:0]        cmp_match;
  logic [0:3]        watch_raw;
  logic [0:3]        bp_raw;
  logic              suppress;
  logic              wr_fetch;
  logic              wr_lsu;

  assign cmp_type[0] = ctrl_reg.cmp_a_type;
  assign cmp_type[1] = ctrl_reg.cmp_b_type;
  assign cmp_type[2] = ctrl_reg.cmp_c_type;
  assign cmp_type[3] = ctrl_reg.cmp_d_type;

  generate
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
      fetch_addr_compare u_cmp (
        .cmp_type   (cmp_type[i]),
        .fetch_word (fetch_req.addr[31:2]),
        .cmp_value  (cmp_value[i]),
        .match      (cmp_match[i])
      );
    end
  endgenerate

  assign wr_fetch = spr_wr_en && (spr_num == SPR_FETCH_WATCH_CONTROL);
  assign wr_lsu   = spr_wr_en && (spr_num == SPR_LOAD_STORE_COMPARE_CONTROL);

  // Watchpoint combining
  always_comb begin
    watch_raw[0] = ctrl_reg.fetch_watch_0_select[1] &&
                   (ctrl_reg.fetch_watch_0_select[0] ? (cmp_match[0] && cmp_match[1]) : cmp_match[0]);
    watch_raw[1] = ctrl_reg.fetch_watch_1_select[1] &&
                   (ctrl_reg.fetch_watch_1_select[0] ? (cmp_match[0] || cmp_match[1]) : cmp_match[1]);
    watch_raw[2] = ctrl_reg.fetch_watch_2_select[1] &&
                   (ctrl_reg.fetch_watch_2_select[0] ? (cmp_match[2] && cmp_match[3]) : cmp_match[2]);
    watch_raw[3] = ctrl_reg.fetch_watch_3_select[1] &&
                   (ctrl_reg.fetch_watch_3_select[0] ? (cmp_match[2] || cmp_match[3]) : cmp_match[3]);
    watch_raw    = fetch_req.valid ? watch_raw : 4'h0;
    bp_raw       = watch_raw & (ctrl_reg.sw_trap_en | ctrl_reg.devport_trap_en);
    suppress     = ctrl_reg.skip_first_hit && !hit_seen_reg;
  end

  // Register file, software and development port writes
  always_comb begin
    ctrl_next = ctrl_reg;
    lsu_next  = lsu_reg;
    if (wr_fetch) begin
      // Software cannot touch the dev-port enables
      ctrl_next                 = fetch_watch_ctrl_t'(spr_wdata);
      ctrl_next.devport_trap_en = ctrl_reg.devport_trap_en;
    end
    if (devport_en_wr) begin
      ctrl_next.devport_trap_en = devport_en_data;
    end
    if (wr_lsu) begin
      lsu_next = load_store_ctrl_t'(spr_wdata & LOAD_STORE_WRITE_MASK);
    end
    rd_hit_next = spr_rd_en && ((spr_num == SPR_FETCH_WATCH_CONTROL) ||
                                (spr_num == SPR_LOAD_STORE_COMPARE_CONTROL));
    rdata_next  = 32'h0000_0000;
    if (spr_rd_en && (spr_num == SPR_FETCH_WATCH_CONTROL)) begin
      rdata_next = ctrl_reg;
    end else if (spr_rd_en && (spr_num == SPR_LOAD_STORE_COMPARE_CONTROL)) begin
      rdata_next = lsu_reg;
    end
  end

  // Show-cycle hand-over: the instruction after the move still sees the old value
  always_comb begin
    show_active_next = show_active_reg;
    show_pend_next   = show_pend_reg;
    if (wr_fetch) begin
      show_pend_next = 1'b1;
    end else if (show_pend_reg && instr_done) begin
      show_active_next = ctrl_reg.show_cycle_sel;
      show_pend_next   = 1'b0;
    end
    serialize_next = !ctrl_reg.serialize_n || (show_active_next == SHOW_ALL);
  end

  // Match outputs and first-hit tracking
  always_comb begin
    hit_next      = watch_raw;
    sw_trap_next  = suppress ? 4'h0 : (watch_raw & ctrl_reg.sw_trap_en);
    dev_trap_next = suppress ? 4'h0 : (watch_raw & ctrl_reg.devport_trap_en);
    hit_seen_next = hit_seen_reg;
    if (wr_fetch) begin
      hit_seen_next = 1'b0;
    end
    // A hit in the same cycle as a rewrite still counts as the skipped one
    if (|bp_raw) begin
      hit_seen_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_reg        <= fetch_watch_ctrl_t'(FETCH_WATCH_CONTROL_RESET);
      lsu_reg         <= load_store_ctrl_t'(LOAD_STORE_CONTROL_RESET);
      show_active_reg <= SHOW_ALL;
      show_pend_reg   <= 1'b0;
      hit_seen_reg    <= 1'b0;
      hit_reg         <= 4'h0;
      sw_trap_reg     <= 4'h0;
      dev_trap_reg    <= 4'h0;
      serialize_reg   <= 1'b1;
      rdata_reg       <= 32'h0000_0000;
      rd_hit_reg      <= 1'b0;
    end else begin
      ctrl_reg        <= ctrl_next;
      lsu_reg         <= lsu_next;
      show_active_reg <= show_active_next;
      show_pend_reg   <= show_pend_next;
      hit_seen_reg    <= hit_seen_next;
      hit_reg         <= hit_next;
      sw_trap_reg     <= sw_trap_next;
      dev_trap_reg    <= dev_trap_next;
      serialize_reg   <= serialize_next;
      rdata_reg       <= rdata_next;
      rd_hit_reg      <= rd_hit_next;
    end
  end

  assign spr_rdata       = rdata_reg;
  assign spr_rd_hit      = rd_hit_reg;
  assign watch_hit       = hit_reg;
  assign sw_trap         = sw_trap_reg;
  assign devport_trap    = dev_trap_reg;
  assign fetch_serialize = serialize_reg;
  assign show_cycle_mode = show_active_reg;
  assign load_store_cfg  = lsu_reg;

  a_reset_clears_ctrl: assert property (@(posedge core_clk) !reset_n |=> (ctrl_reg == 32'h0 && !fetch_serialize == 1'b0))
    else $error("control not cleared by reset");

  a_cmp_inactive_nohit: assert property (@(posedge core_clk) disable iff (!reset_n)
    (fetch_req.valid && !ctrl_reg.cmp_a_type[2] && ctrl_reg.fetch_watch_0_select == WATCH_SINGLE) |=> !watch_hit[0])
    else $error("inactive comparator produced a hit");

  a_watch_pair_and: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.fetch_watch_0_select == WATCH_PAIR) |=> (watch_hit[0] == $past(fetch_req.valid && cmp_match[0] && cmp_match[1])))
    else $error("watch 0 pair mode wrong");

  a_watch_pair_or: assert property (@(posedge core_clk) disable iff (!reset_n)
    (fetch_req.valid && ctrl_reg.fetch_watch_1_select == WATCH_PAIR && (cmp_match[0] || cmp_match[1])) |=> watch_hit[1])
    else $error("watch 1 or mode missed");

  a_sw_trap_fire: assert property (@(posedge core_clk) disable iff (!reset_n)
    (watch_raw[2] && ctrl_reg.sw_trap_en[2] && !suppress) |=> sw_trap[2])
    else $error("software trap missed");

  a_devport_ro_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wr_fetch && !devport_en_wr) |=> $stable(ctrl_reg.devport_trap_en))
    else $error("software altered dev-port enables");

  a_skip_first_hit: assert property (@(posedge core_clk) disable iff (!reset_n)
    (suppress && |bp_raw) |=> (sw_trap == 4'h0 && devport_trap == 4'h0 && hit_seen_reg))
    else $error("first hit not skipped");

  a_serialize_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 (fetch_serialize == (!$past(ctrl_reg.serialize_n) || show_cycle_mode == SHOW_ALL)))
    else $error("serialize level wrong");

  a_show_old_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_fetch |=> ($stable(show_cycle_mode) ##1 (show_cycle_mode == $past(ctrl_reg.show_cycle_sel) || !$past(instr_done))))
    else $error("show select changed too early");

  a_lsu_write_back: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_lsu |=> (load_store_cfg == $past(spr_wdata & LOAD_STORE_WRITE_MASK)))
    else $error("load/store control write lost");

endmodule : ibus_watchpoint_control
`default_nettype wire

// >>> hdl/ibus_watch_pkg.sv
package ibus_watch_pkg;

  // Special-register numbers used by the move instructions
  localparam logic [9:0] SPR_LOAD_STORE_COMPARE_CONTROL = 10'h09c;
  localparam logic [9:0] SPR_FETCH_WATCH_CONTROL        = 10'h09e;

  localparam logic [31:0] FETCH_WATCH_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] LOAD_STORE_CONTROL_RESET  = 32'h0000_0000;
  // Bits 30:31 of the load/store control are reserved and read as zero
  localparam logic [31:0] LOAD_STORE_WRITE_MASK     = 32'hffff_fffc;

  // Compare-type codes, shared by instruction and load/store comparators
  localparam logic [2:0] CMP_EQUAL     = 3'h4;
  localparam logic [2:0] CMP_LESS      = 3'h5;
  localparam logic [2:0] CMP_GREATER   = 3'h6;
  localparam logic [2:0] CMP_NOT_EQUAL = 3'h7;

  // Watchpoint select codes; top bit clear means inactive
  localparam logic [1:0] WATCH_SINGLE  = 2'h2;
  localparam logic [1:0] WATCH_PAIR    = 2'h3;

  // Show-cycle codes
  localparam logic [1:0] SHOW_ALL      = 2'h0;
  localparam logic [1:0] SHOW_FLOW     = 2'h1;
  localparam logic [1:0] SHOW_INDIRECT = 2'h2;
  localparam logic [1:0] SHOW_NONE     = 2'h3;

  localparam int NUM_CMP = 4;

  // Field order follows the register from bit 0 (most significant) down
  typedef struct packed {
    logic [2:0] cmp_a_type;
    logic [2:0] cmp_b_type;
    logic [2:0] cmp_c_type;
    logic [2:0] cmp_d_type;
    logic [1:0] fetch_watch_0_select;
    logic [1:0] fetch_watch_1_select;
    logic [1:0] fetch_watch_2_select;
    logic [1:0] fetch_watch_3_select;
    logic [0:3] sw_trap_en;
    logic [0:3] devport_trap_en;
    logic       skip_first_hit;
    logic       serialize_n;
    logic [1:0] show_cycle_sel;
  } fetch_watch_ctrl_t;

  typedef struct packed {
    logic [2:0] cmp_e_type;
    logic [2:0] cmp_f_type;
    logic [2:0] cmp_g_type;
    logic [2:0] cmp_h_type;
    logic [1:0] cmp_e_dir;
    logic [1:0] cmp_f_dir;
    logic [1:0] cmp_g_size;
    logic [1:0] cmp_h_size;
    logic       cmp_g_signed;
    logic       cmp_h_signed;
    logic [3:0] cmp_g_byte_mask;
    logic [3:0] cmp_h_byte_mask;
    logic [1:0] reserved;
  } load_store_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } fetch_req_t;

endpackage : ibus_watch_pkg

// >>> hdl/fetch_addr_compare.sv
`timescale 1ns/1ps
`default_nettype none
module fetch_addr_compare (
  input  wire logic [2:0]  cmp_type,
  input  wire logic [29:0] fetch_word,
  input  wire logic [29:0] cmp_value,
  output logic             match
);
  import ibus_watch_pkg::*;

  always_comb begin
    match = 1'b0;
    if (cmp_type[2]) begin
      case (cmp_type)
        CMP_EQUAL:     match = (fetch_word == cmp_value);
        CMP_LESS:      match = (fetch_word <  cmp_value);
        CMP_GREATER:   match = (fetch_word >  cmp_value);
        CMP_NOT_EQUAL: match = (fetch_word != cmp_value);
        default:       match = 1'b0;
      endcase
    end
  end
endmodule : fetch_addr_compare
`default_nettype wire

// >>> dv/fetch_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module fetch_side_model (
  input  wire logic                 core_clk,
  input  wire logic                 fetch_go,
  input  wire logic [31:0]          fetch_addr,
  input  wire logic                 done_go,
  output var ibus_watch_pkg::fetch_req_t fetch_req,
  output logic                      instr_done
);
  import ibus_watch_pkg::*;
  // Outputs have one driver only; the design is held in reset until the first edge loads them
  logic [31:0] last_addr = 32'h0000_0000;
  // Idle cycles show the inverse of the last address so a stale one never matches by luck
  always @(posedge core_clk) begin
    fetch_req.valid <= fetch_go;
    fetch_req.addr <= fetch_go ? fetch_addr : ~last_addr;
    if (fetch_go) last_addr <= fetch_addr;
    instr_done <= done_go;
  end
endmodule : fetch_side_model
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ibus_watch_pkg::*;
  logic core_clk, reset_n, spr_wr_en, spr_rd_en, spr_rd_hit, devport_en_wr, instr_done;
  logic fetch_serialize, fetch_go, done_go, fv;
  logic [9:0] spr_num;
  logic [31:0] spr_wdata, spr_rdata, fetch_addr, seed;
  logic [0:3] devport_en_data, watch_hit, sw_trap, devport_trap;
  logic [3:0][29:0] cmp_value;
  logic [1:0] show_cycle_mode;
  fetch_req_t fetch_req;
  load_store_ctrl_t load_store_cfg;
  int errors, checks, cycles;
  logic [31:0] rd_q[$];
  logic [11:0] hit_q[$];

  ibus_watchpoint_control dut_u (.core_clk, .reset_n, .spr_wr_en, .spr_rd_en, .spr_num, .spr_wdata,
    .spr_rdata, .spr_rd_hit, .devport_en_wr, .devport_en_data, .fetch_req, .cmp_value, .instr_done,
    .watch_hit, .sw_trap, .devport_trap, .fetch_serialize, .show_cycle_mode, .load_store_cfg);
  fetch_side_model model_u (.core_clk, .fetch_go, .fetch_addr, .done_go, .fetch_req, .instr_done);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs
  function automatic logic cmp_hit(input logic [2:0] t, input logic [29:0] a, input logic [29:0] v);
    case (t)
      CMP_EQUAL: return a == v;
      CMP_LESS: return a < v;
      CMP_GREATER: return a > v;
      CMP_NOT_EQUAL: return a != v;
      default: return 1'b0;
    endcase
  endfunction : cmp_hit
  function automatic logic sel_hit(input logic [1:0] s, input logic one, input logic two);
    return s[1] & (s[0] ? two : one);
  endfunction : sel_hit
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, e, got);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // Unmapped reads leave no note, so any stray hit finds the queue empty
  task automatic acc(input logic w, input logic [9:0] num, input logic [31:0] d);
    if (!w && (num == SPR_FETCH_WATCH_CONTROL || num == SPR_LOAD_STORE_COMPARE_CONTROL)) rd_q.push_back(d);
    @(posedge core_clk);
    spr_wr_en <= w;
    spr_rd_en <= !w;
    spr_num <= num;
    spr_wdata <= d;
    @(posedge core_clk);
    spr_wr_en <= 1'b0;
    spr_rd_en <= 1'b0;
  endtask : acc
  task automatic pulse(input logic dev, input logic [0:3] d);
    @(posedge core_clk);
    done_go <= !dev;
    devport_en_wr <= dev;
    devport_en_data <= d;
    @(posedge core_clk);
    done_go <= 1'b0;
    devport_en_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : pulse
  task automatic fetch(input logic [31:0] addr, input logic [3:0][29:0] cv, input logic [11:0] e);
    hit_q.push_back(e);
    @(posedge core_clk);
    cmp_value <= cv;
    fetch_go <= 1'b1;
    fetch_addr <= addr;
    @(posedge core_clk);
    fetch_go <= 1'b0;
  endtask : fetch

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) fv <= fetch_req.valid;
  always @(negedge core_clk) begin
    if (spr_rd_hit === 1'b1) chk("read data", rd_q.size() ? rd_q.pop_front() : 32'hdead, spr_rdata);
    if (fv === 1'b1) begin
      chk("fetch result", hit_q.size() ? 32'(hit_q.pop_front()) : 32'hdead,
          {20'h0, watch_hit, sw_trap, devport_trap});
    end
  end
  // Whole run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    fetch_watch_ctrl_t c;
    logic [3:0][29:0] v;
    logic [0:3] m, hw, dp;
    logic [29:0] a;
    logic [1:0] prev;
    {reset_n, spr_wr_en, spr_rd_en, devport_en_wr, fetch_go, done_go} = '0;
    {spr_num, spr_wdata, fetch_addr, devport_en_data, cmp_value, v} = '0;
    {errors, checks} = '0;
    seed = 32'h5253cf3b;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk("reset outputs", 32'h1000, {show_cycle_mode, fetch_serialize, watch_hit, sw_trap, devport_trap});
    chk("load store reset", LOAD_STORE_CONTROL_RESET, load_store_cfg);
    acc(0, SPR_FETCH_WATCH_CONTROL, FETCH_WATCH_CONTROL_RESET);
    acc(0, SPR_LOAD_STORE_COMPARE_CONTROL, LOAD_STORE_CONTROL_RESET);
    acc(1, SPR_FETCH_WATCH_CONTROL, 32'hffffffff);
    acc(0, SPR_FETCH_WATCH_CONTROL, 32'hffffff0f);
    dp = 4'b1010;
    pulse(1, dp);
    acc(0, SPR_FETCH_WATCH_CONTROL, 32'hffffffaf);
    seed = xs(seed);
    acc(1, SPR_LOAD_STORE_COMPARE_CONTROL, seed);
    acc(0, SPR_LOAD_STORE_COMPARE_CONTROL, seed & LOAD_STORE_WRITE_MASK);
    acc(0, 10'h09d, 32'h0);
    #1 chk("load store out", seed & LOAD_STORE_WRITE_MASK, load_store_cfg);
    pulse(0, dp);
    prev = SHOW_NONE;
    for (int k = 0; k < 8; k++) begin
      c = '0;
      c.serialize_n = k[2];
      c.show_cycle_sel = k[1:0];
      acc(1, SPR_FETCH_WATCH_CONTROL, c);
      #1 chk("show held", 32'(prev), 32'(show_cycle_mode));
      pulse(0, dp);
      chk("show mode", 32'(k[1:0]), 32'(show_cycle_mode));
      chk("serialize", 32'(!k[2] || k[1:0] == 2'h0), 32'(fetch_serialize));
      prev = k[1:0];
    end
    for (int n = 0; n < 48; n++) begin
      seed = xs(seed);
      c = fetch_watch_ctrl_t'(seed);
      c.skip_first_hit = 1'b0;
      acc(1, SPR_FETCH_WATCH_CONTROL, c);
      for (int i = 0; i < 4; i++) begin
        seed = xs(seed);
        v[i] = seed[29:0];
      end
      seed = xs(seed);
      a = v[seed[1:0]] + {28'h0, seed[3:2]} - 30'h1;
      m = {cmp_hit(c.cmp_a_type, a, v[0]), cmp_hit(c.cmp_b_type, a, v[1]),
           cmp_hit(c.cmp_c_type, a, v[2]), cmp_hit(c.cmp_d_type, a, v[3])};
      hw = {sel_hit(c.fetch_watch_0_select, m[0], m[0] & m[1]), sel_hit(c.fetch_watch_1_select, m[1], m[0] | m[1]),
            sel_hit(c.fetch_watch_2_select, m[2], m[2] & m[3]), sel_hit(c.fetch_watch_3_select, m[3], m[2] | m[3])};
      fetch({a, seed[5:4]}, v, {hw, hw & c.sw_trap_en, hw & dp});
    end
    c = '0;
    c.cmp_a_type = CMP_EQUAL;
    c.fetch_watch_0_select = WATCH_SINGLE;
    c.sw_trap_en = 4'b1000;
    c.skip_first_hit = 1'b1;
    acc(1, SPR_FETCH_WATCH_CONTROL, c);
    fetch({v[0], 2'h0}, v, 12'h800);
    fetch({v[0], 2'h0}, v, 12'h888);
    repeat (4) @(posedge core_clk);
    chk("pending notes", 32'h0, rd_q.size() + hit_q.size());
    summarize();
  end
endmodule : tb_top
`default_nettype wire
